//--- dcs_regs.svh
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DCS_OFF_CTRL 12'h000
`define DCS_OFF_SETUP 12'h004
`define DCS_OFF_ACTIVE 12'h008
`define DCS_OFF_DIR 12'h00C
`define DCS_OFF_STATUS 12'h010
`define DCS_OFF_ADDRCHK 12'h014
// ----------------------------------------
// setup word fields
// ----------------------------------------
`define DCS_F_ADDR_LSB 0
`define DCS_F_BAUD_LSB 8
`define DCS_F_PAR_LSB 12
`define DCS_F_LF_BIT 14
`define DCS_F_ECHO_BIT 15
`define DCS_F_DLY_LSB 16
// ----------------------------------------
// reset and fallback values
// ----------------------------------------
`define DCS_ADDR_INIT 8'h31
`define DCS_BAUD_300 4'h0
`define DCS_PAR_NONE 2'h0
`define DCS_DLY_INIT 4'h2
`define DCS_DIR_INIT 15'h0000
`define DCS_CHAN_NUM 15
`define DCS_CH_NUL 8'h00
`define DCS_CH_CR 8'h0D
`define DCS_CH_DOLLAR 8'h24
`define DCS_CH_HASH 8'h23
`define DCS_CH_PROMPT 8'h3F
`define DCS_RST_CYCLES 4'h8
`endif

//--- dcs_pkg.sv
package dcs_pkg;
  typedef struct packed {
    logic [3:0] dly;
    logic echo;
    logic lf;
    logic [1:0] par;
    logic [3:0] baud;
    logic [7:0] addr;
  } dcs_setup_t;

  typedef struct packed {
    logic [3:0] baud;
    logic [1:0] par;
    logic [1:0] stop_bits;
    logic [3:0] data_bits;
    logic any_addr;
  } dcs_link_t;

  typedef enum logic [1:0] {
    DCS_RUN = 2'b00,
    DCS_FALLBACK = 2'b01,
    DCS_RELOAD = 2'b11
  } dcs_state_t;
endpackage : dcs_pkg

//--- dcs_chan_dir.sv
`timescale 1ns/10ps
`include "dcs_regs.svh"
// one channel direction cell, loaded from stored direction at power up
module dcs_chan_dir
  import dcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic stored_dir,
  output logic is_output
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_output <= 1'b0;
    end else if (load) begin
      is_output <= stored_dir;
    end
  end
endmodule : dcs_chan_dir

//--- dcs_setup_select.sv
// Functional notes
// R1: grounded force pin selects fallback link setup
// R2: fallback is 300 baud, 8N1
// R3: fallback accepts any address except reserved four
// R4: fallback never alters stored settings
// R5: readback returns stored setup in any mode
// R6: all commands stay usable in fallback
// R7: host always sends an address character
// R8: error reply puts address after question mark
// R9: setup writes in fallback update stored setup only
// R10: pin release forces reset, reloads stored link
// R11: stored channel directions applied at power up
// R12: channels set individually or all at once
// R13: factory setup addr 1, 300, 8N1, delay 2
// R14: force pin sampled synchronously, low active
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "dcs_regs.svh"
module dcs_setup_select
  import dcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic default_force_n,
  output dcs_link_t link_cfg,
  output logic [7:0] addr_match_char,
  output logic addr_hit,
  output logic [7:0] err_prefix_addr,
  output logic prog_reset,
  output logic [14:0] chan_is_output
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic sel_ctrl = paddr == `DCS_OFF_CTRL;
  wire logic sel_setup = paddr == `DCS_OFF_SETUP;
  wire logic sel_active = paddr == `DCS_OFF_ACTIVE;
  wire logic sel_dir = paddr == `DCS_OFF_DIR;
  wire logic sel_status = paddr == `DCS_OFF_STATUS;
  wire logic sel_chk = paddr == `DCS_OFF_ADDRCHK;
  wire logic mapped = sel_ctrl | sel_setup | sel_active | sel_dir | sel_status | sel_chk;

  // ----------------------------------------
  // force pin and mode
  // ----------------------------------------
  logic force_q;
  dcs_state_t state;
  dcs_state_t next_state;
  logic [3:0] rst_cnt;
  wire logic release_edge = !force_q && default_force_n; // see R14
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_q <= 1'b1;
    end else begin
      force_q <= default_force_n; // see R14
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      DCS_RUN: begin
        if (!default_force_n) next_state = DCS_FALLBACK; // see R1
      end
      DCS_FALLBACK: begin
        if (release_edge) next_state = DCS_RELOAD; // see R10
      end
      DCS_RELOAD: begin
        if (rst_cnt == 4'h1) next_state = DCS_RUN;
      end
      default: next_state = DCS_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DCS_RUN;
      rst_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (next_state == DCS_RELOAD && state != DCS_RELOAD) rst_cnt <= `DCS_RST_CYCLES;
      else if (rst_cnt != 4'h0) rst_cnt <= rst_cnt - 4'h1;
    end
  end
  wire logic fallback = state == DCS_FALLBACK;

  // ----------------------------------------
  // stored setup, never touched by the mode
  // ----------------------------------------
  dcs_setup_t stored;
  logic [14:0] stored_dir;
  logic [14:0] next_dir;
  logic [7:0] chk_char;
  // setup writes go to storage in every mode; active link is separate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored <= '{dly: `DCS_DLY_INIT, echo: 1'b0, lf: 1'b0, par: `DCS_PAR_NONE,
                  baud: `DCS_BAUD_300, addr: `DCS_ADDR_INIT}; // see R13
      stored_dir <= `DCS_DIR_INIT;
      chk_char <= 8'h00;
    end else begin
      if (wr && sel_setup) stored <= dcs_setup_t'(pwdata[19:0]); // see R9, R4, R6
      if (wr && sel_dir) stored_dir <= next_dir; // see R12
      if (wr && sel_chk) chk_char <= pwdata[7:0];
    end
  end
  // bit 16 set writes all channels from bit 0, else per channel mask
  always_comb begin
    next_dir = stored_dir;
    if (pwdata[16]) next_dir = {15{pwdata[0]}}; // see R12
    else next_dir = pwdata[14:0]; // see R12
  end

  // ----------------------------------------
  // channel directions
  // ----------------------------------------
  // applied after power up and after the self reset; a trade-off: live
  // direction only follows storage on those events, like the real module
  logic dir_load;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_load <= 1'b1;
    end else begin
      dir_load <= (state == DCS_RELOAD && rst_cnt == 4'h1); // see R11
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < `DCS_CHAN_NUM; gi++) begin : g_ch
      dcs_chan_dir u_dir (
        .pclk(pclk),
        .presetn(presetn),
        .load(dir_load),
        .stored_dir(stored_dir[gi]),
        .is_output(chan_is_output[gi])
      ); // see R11
    end
  endgenerate

  // ----------------------------------------
  // active link and address check
  // ----------------------------------------
  wire logic reserved = chk_char == `DCS_CH_NUL || chk_char == `DCS_CH_CR ||
                        chk_char == `DCS_CH_DOLLAR || chk_char == `DCS_CH_HASH;
  wire logic hit = fallback ? !reserved : (chk_char == stored.addr); // see R3
  dcs_link_t next_link;
  always_comb begin
    next_link = link_cfg;
    if (fallback) begin
      next_link = '{baud: `DCS_BAUD_300, par: `DCS_PAR_NONE, stop_bits: 2'd1,
                    data_bits: 4'd8, any_addr: 1'b1}; // see R1, R2, R9
    end else if (state == DCS_RELOAD) begin
      next_link = '{baud: stored.baud, par: stored.par, stop_bits: 2'd1,
                    data_bits: 4'd8, any_addr: 1'b0}; // see R10
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_cfg <= '{baud: `DCS_BAUD_300, par: `DCS_PAR_NONE, stop_bits: 2'd1,
                    data_bits: 4'd8, any_addr: 1'b0};
      addr_hit <= 1'b0;
      addr_match_char <= `DCS_ADDR_INIT;
      err_prefix_addr <= `DCS_ADDR_INIT;
      prog_reset <= 1'b0;
    end else begin
      link_cfg <= next_link;
      addr_hit <= hit;
      addr_match_char <= stored.addr;
      err_prefix_addr <= stored.addr; // see R8
      prog_reset <= next_state == DCS_RELOAD; // see R10
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  wire logic [31:0] rd_mux =
    sel_setup ? {12'h000, stored} : // see R5
    sel_active ? {19'h00000, link_cfg} :
    sel_dir ? {17'h00000, stored_dir} :
    sel_status ? {16'h0000, err_prefix_addr, 4'h0, addr_hit, prog_reset, state} :
    sel_chk ? {16'h0000, `DCS_CH_PROMPT, chk_char} :
    32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // checks: length of the self reset
  // ----------------------------------------
  logic [3:0] pr_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr_len <= 4'h0;
    end else begin
      pr_len <= prog_reset ? pr_len + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------
  // checks: bus
  // ----------------------------------------
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    psel && !penable |=> pready)
    else $error("access cycle without ready");
  a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    !(psel && !penable) |=> !pready)
    else $error("ready outside access cycle");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    psel && !penable && mapped |=> !pslverr)
    else $error("mapped access flagged");
  a_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    !(psel && !penable && !pwrite) |=> prdata == 32'h0000_0000)
    else $error("read data outside read access");
  a_setup_read: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    psel && !penable && !pwrite && sel_setup |=> prdata[19:0] == $past(stored))
    else $error("readback wrong");
  a_status_read: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    psel && !penable && !pwrite && sel_status |=> prdata[15:8] == $past(err_prefix_addr))
    else $error("status address wrong");
  a_prompt_read: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    psel && !penable && !pwrite && sel_chk |=> prdata[15:8] == `DCS_CH_PROMPT)
    else $error("prompt char wrong");
  a_dir_read: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    psel && !penable && !pwrite && sel_dir |=> prdata[14:0] == $past(stored_dir))
    else $error("direction readback wrong");
  a_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    wr && !mapped |=> $stable(stored) && $stable(stored_dir) && $stable(chk_char))
    else $error("unmapped write landed");

  // ----------------------------------------
  // checks: mode
  // ----------------------------------------
  a_enter_fallback: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    state == DCS_RUN && !default_force_n |=> state == DCS_FALLBACK)
    else $error("grounded pin did not enter fallback");
  a_stay_fallback: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    fallback && !default_force_n |=> fallback)
    else $error("fallback left while pin low");
  a_sync_force: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    1'b1 |=> force_q == $past(default_force_n))
    else $error("force pin sample wrong");
  a_no_early_reload: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    state == DCS_RUN |=> state != DCS_RELOAD)
    else $error("reload without release");
  a_fallback_link: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    state == DCS_FALLBACK |=> link_cfg.baud == `DCS_BAUD_300 && link_cfg.par == `DCS_PAR_NONE)
    else $error("fallback link not 300 8N1");
  a_any_addr_flag: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    fallback |=> link_cfg.any_addr)
    else $error("fallback link not any address");
  a_release_reset: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    state == DCS_FALLBACK && release_edge |=> prog_reset ##[8:9] state == DCS_RUN)
    else $error("release did not self reset");
  a_reset_length: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    $fell(prog_reset) |-> pr_len == `DCS_RST_CYCLES)
    else $error("self reset length wrong");
  a_reset_bound: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    prog_reset |-> pr_len < `DCS_RST_CYCLES)
    else $error("self reset too long");
  a_reload_link: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    $fell(state == DCS_RELOAD) && state == DCS_RUN |-> link_cfg.baud == stored.baud
      && link_cfg.par == stored.par)
    else $error("stored baud not reloaded");
  a_run_link_kept: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    state == DCS_RUN && next_state == DCS_RUN |=> $stable(link_cfg))
    else $error("link changed in run");

  // ----------------------------------------
  // checks: address
  // ----------------------------------------
  a_reserved_reject: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    fallback && chk_char == `DCS_CH_HASH |=> !addr_hit)
    else $error("reserved char accepted");
  a_fallback_any: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    fallback && !reserved |=> addr_hit)
    else $error("fallback rejected address");
  a_run_addr_match: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    !fallback && chk_char == stored.addr |=> addr_hit)
    else $error("stored address rejected");
  a_chk_store: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    wr && sel_chk |=> chk_char == $past(pwdata[7:0]))
    else $error("check char not stored");
  a_err_addr: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    ##1 err_prefix_addr == $past(stored.addr))
    else $error("error prefix not address");
  a_match_char: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    1'b1 |=> addr_match_char == $past(stored.addr))
    else $error("address char not stored one");

  // ----------------------------------------
  // checks: storage
  // ----------------------------------------
  a_store_kept: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    $fell(default_force_n) && !(wr && sel_setup) |=> $stable(stored))
    else $error("stored setup changed by pin");
  a_store_mode: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    next_state != state && !(wr && sel_setup) |=> $stable(stored))
    else $error("stored setup changed by mode");
  a_write_stores: assert property (@(posedge pclk) disable iff (!presetn) // see R9
    wr && sel_setup && fallback |=> stored == dcs_setup_t'($past(pwdata[19:0]))
      && link_cfg.baud == `DCS_BAUD_300)
    else $error("fallback setup write wrong");
  a_dir_kept: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    !(wr && sel_dir) |=> $stable(stored_dir))
    else $error("stored directions changed");
  a_dir_all: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    wr && sel_dir && pwdata[16] |=> stored_dir == {15{$past(pwdata[0])}})
    else $error("all channel write wrong");
  a_dir_apply: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    dir_load |=> chan_is_output == $past(stored_dir))
    else $error("directions not applied");
  a_live_dir_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    !dir_load |=> $stable(chan_is_output))
    else $error("live directions moved");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_fallback: cover property (@(posedge pclk) disable iff (!presetn)
    state == DCS_FALLBACK);
  c_reload: cover property (@(posedge pclk) disable iff (!presetn)
    state == DCS_RELOAD ##8 state == DCS_RUN);
  c_fb_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr && sel_setup && fallback);
  c_release: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(prog_reset));
endmodule : dcs_setup_select

//--- dcs_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// host terminal, fixed at 300 baud 8n1
// ----------------------------------------
module dcs_host_model
  import dcs_pkg::*;
(
  input wire logic pclk,
  input wire dcs_link_t link_cfg,
  output logic [7:0] cmd_addr,
  output logic link_match
);
  // dummy address, never one of the reserved four
  assign cmd_addr = 8'h5A;
  // host cannot retune, so a mismatch means silence
  always_ff @(posedge pclk) begin
    link_match <= (link_cfg.baud == 4'h0) && (link_cfg.par == 2'h0)
      && (link_cfg.data_bits == 4'h8) && (link_cfg.stop_bits == 2'h1);
  end
endmodule : dcs_host_model

//--- default_comm_setup_select_tb.sv
`timescale 1ns/10ps
`include "dcs_regs.svh"
module default_comm_setup_select_tb
  import dcs_pkg::*;
;
  // ----------------------------------------
  // signals and expected link setups
  // ----------------------------------------
  localparam dcs_link_t L_RUN0 = '{4'h0, 2'h0, 2'h1, 4'h8, 1'b0};
  localparam dcs_link_t L_FB = '{4'h0, 2'h0, 2'h1, 4'h8, 1'b1};
  localparam dcs_link_t L_RUN5 = '{4'h5, 2'h1, 2'h1, 4'h8, 1'b0};
  logic pclk, presetn, psel, penable, pwrite, default_force_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, addr_hit, prog_reset, link_match;
  dcs_link_t link_cfg;
  logic [7:0] addr_match_char, err_prefix_addr, cmd_addr;
  logic [14:0] chan_is_output;
  int n_mismatch = 0;
  int checks = 0;
  int cnt;
  logic [7:0] rsv [4] = '{8'h00, 8'h0D, 8'h24, 8'h23};
  dcs_setup_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .default_force_n(default_force_n), .link_cfg(link_cfg),
    .addr_match_char(addr_match_char), .addr_hit(addr_hit),
    .err_prefix_addr(err_prefix_addr), .prog_reset(prog_reset),
    .chan_is_output(chan_is_output));
  dcs_host_model host_u (.pclk(pclk), .link_cfg(link_cfg), .cmd_addr(cmd_addr),
    .link_match(link_match));
  always #50 pclk = ~pclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic nap(input int n);
    repeat (n) @(negedge pclk);
  endtask : nap
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e_er);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, e_er});
  endtask : rd_chk
  task automatic tally_and_finish;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #200_000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0000_0000; default_force_n = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    nap(2);
    chk(32'(link_cfg), 32'(L_RUN0));
    rd_chk(`DCS_OFF_SETUP, 32'h0002_0031, 1'b0);
    rd_chk(12'h0FC, 32'h0000_0000, 1'b1);
    @(posedge pclk);
    default_force_n <= 1'b0;
    nap(3);
    chk(32'(link_cfg), 32'(L_FB));
    chk({31'h0, link_match}, 32'h0000_0001);
    chk({24'h0, addr_match_char}, 32'h0000_0031);
    rd_chk(`DCS_OFF_SETUP, 32'h0002_0031, 1'b0);
    rd_chk(`DCS_OFF_ACTIVE, 32'(L_FB), 1'b0);
    foreach (rsv[i]) begin
      wr(`DCS_OFF_ADDRCHK, {24'h0, rsv[i]});
      nap(2);
      chk({31'h0, addr_hit}, 32'h0000_0000);
    end
    wr(`DCS_OFF_ADDRCHK, {24'h0, cmd_addr});
    nap(2);
    chk({31'h0, addr_hit}, 32'h0000_0001);
    rd_chk(`DCS_OFF_ADDRCHK, {16'h0, 8'h3F, cmd_addr}, 1'b0);
    chk({24'h0, err_prefix_addr}, 32'h0000_0031);
    rd_chk(`DCS_OFF_STATUS, 32'h0000_3109, 1'b0);
    wr(`DCS_OFF_SETUP, 32'h0002_1541);
    nap(2);
    rd_chk(`DCS_OFF_SETUP, 32'h0002_1541, 1'b0);
    chk(32'(link_cfg), 32'(L_FB));
    wr(`DCS_OFF_DIR, 32'h0001_0001);
    rd_chk(`DCS_OFF_DIR, 32'h0000_7FFF, 1'b0);
    chk({17'h0, chan_is_output}, 32'h0000_0000);
    wr(`DCS_OFF_DIR, 32'h0000_0005);
    rd_chk(`DCS_OFF_DIR, 32'h0000_0005, 1'b0);
    @(posedge pclk);
    default_force_n <= 1'b1;
    cnt = 0;
    while (prog_reset !== 1'b1 && cnt < 10) begin
      nap(1);
      cnt++;
    end
    cnt = 0;
    while (prog_reset === 1'b1 && cnt < 20) begin
      nap(1);
      cnt++;
    end
    chk(32'(cnt), 32'h0000_0008);
    nap(3);
    chk(32'(link_cfg), 32'(L_RUN5));
    chk({17'h0, chan_is_output}, 32'h0000_0005);
    chk({24'h0, err_prefix_addr}, 32'h0000_0041);
    chk({24'h0, addr_match_char}, 32'h0000_0041);
    chk({31'h0, link_match}, 32'h0000_0000);
    // outside fallback only the stored address may match
    wr(`DCS_OFF_ADDRCHK, {24'h0, cmd_addr});
    nap(2);
    chk({31'h0, addr_hit}, 32'h0000_0000);
    wr(`DCS_OFF_ADDRCHK, 32'h0000_0041);
    nap(2);
    chk({31'h0, addr_hit}, 32'h0000_0001);
    tally_and_finish;
  end
endmodule : default_comm_setup_select_tb
